// file: hw/dsrf_params.svh
`ifndef DSRF_PARAMS_SVH
`define DSRF_PARAMS_SVH
// documented configuration variable numbers
`define DSRF_CV_FBOPT 8'h1C
`define DSRF_CV_BASIC 8'h1D
`define DSRF_CV_RETAIN 8'h7A
`define DSRF_CV_DIR 8'h7C
// meaningful bit positions
`define DSRF_BIT_AUTOREG 7
`define DSRF_BIT_FB_EN 3
`define DSRF_BIT_SAVE_FUNC 0
`define DSRF_BIT_SAVE_SPD 1
`define DSRF_BIT_DIRBIT 0
// factory values after srst
`define DSRF_RST_FBOPT 8'h80
`define DSRF_RST_BASIC 8'h08
`define DSRF_RST_RETAIN 8'h00
`define DSRF_RST_DIR 8'h00
// writable bits, all others hold their value
`define DSRF_MSK_FBOPT 8'h80
`define DSRF_MSK_BASIC 8'h08
`define DSRF_MSK_RETAIN 8'h03
`define DSRF_MSK_DIR 8'h01
`define DSRF_MSK_ALL 8'hFF
// registration record (name, key symbols, latching flags), last init step, stop speed
`define DSRF_REG_BASE 8'hC0
`define DSRF_REG_LAST 6'h3F
`define DSRF_INIT_LAST 2'h3
`define DSRF_SPEED_STOP 8'h00
`endif

// file: hw/dsrf_pkg.sv
`default_nettype none
package dsrf_pkg;
  typedef enum logic [3:0] {
    DSRF_ST_INIT = 4'h1,
    DSRF_ST_IDLE = 4'h2,
    DSRF_ST_CV = 4'h4,
    DSRF_ST_REG = 4'h8
  } dsrf_state_t;
  typedef enum logic [1:0] {
    DSRF_FB_ADDR = 2'h0,
    DSRF_FB_CV = 2'h1,
    DSRF_FB_STAT = 2'h2,
    DSRF_FB_REG = 2'h3
  } dsrf_fb_kind_t;
endpackage
`default_nettype wire

// file: hw/dsrf_mem_if.sv
`default_nettype none
interface dsrf_mem_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;
  modport ctl (output addr, output wdata, output we, output re,
    input rdata);
  modport mem (input addr, input wdata, input we, input re,
    output rdata);
endinterface
`default_nettype wire

// file: hw/dsrf_cv_mem.sv
`default_nettype none
module dsrf_cv_mem (
  input wire logic ref_clk,
  dsrf_mem_if.mem port
);
  // cells have no reset; after srst the init state rewrites only the four documented variables
  logic [7:0] cells [256];
  logic [7:0] rdata_q;

  // one write and one read per cycle, read data registered
  always_ff @(posedge ref_clk)
  begin
    if (port.we)
      cells[port.addr] <= port.wdata;
    if (port.re)
      rdata_q <= cells[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// file: hw/dsrf_top.sv
// The plain strobed port was chosen for this implementation.
`include "dsrf_params.svh"
`default_nettype none
// Notes on behaviour
// - analogue to digital direction only when enabled
// - save functions, restore them after power loss
// - save speed, resume it, ignore station speed
// - send locomotive address on broadcast request
// - report any configuration value on request
// - send motor load, current, temperature status
// - feedback channel off unless enable bit set
// - automatic registration unless its bit cleared
// - registration sends name, symbols, latching flags
module dsrf_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic trk_power_ok,
  input wire logic trk_speed_stb,
  input wire logic [7:0] trk_speed,
  input wire logic trk_dir,
  input wire logic trk_func_stb,
  input wire logic [28:0] trk_func,
  input wire logic trk_a2d_entry,
  input wire logic trk_analog_dir,
  input wire logic trk_addr_bcast,
  input wire logic trk_cv_query,
  input wire logic [7:0] trk_cv_num,
  input wire logic trk_stat_query,
  input wire logic [1:0] trk_stat_sel,
  input wire logic trk_reg_start,
  input wire logic [13:0] loco_addr,
  input wire logic [7:0] motor_load,
  input wire logic [7:0] motor_current,
  input wire logic [7:0] motor_temp,
  output logic [7:0] drv_speed,
  output logic drv_dir,
  output logic [28:0] drv_func,
  output logic resume_hold,
  output logic fb_valid,
  output logic [1:0] fb_kind,
  output logic [15:0] fb_data
);
  dsrf_mem_if mif ();

  dsrf_cv_mem u_mem (
    .ref_clk(ref_clk),
    .port(mif.mem)
  );

  // decode of the four documented variables, shared by several paths
  function automatic logic [7:0] doc_addr(input logic [1:0] i);
    case (i)
      2'h0: doc_addr = `DSRF_CV_FBOPT;
      2'h1: doc_addr = `DSRF_CV_BASIC;
      2'h2: doc_addr = `DSRF_CV_RETAIN;
      default: doc_addr = `DSRF_CV_DIR;
    endcase
  endfunction

  function automatic logic [7:0] doc_rst(input logic [1:0] i);
    case (i)
      2'h0: doc_rst = `DSRF_RST_FBOPT;
      2'h1: doc_rst = `DSRF_RST_BASIC;
      2'h2: doc_rst = `DSRF_RST_RETAIN;
      default: doc_rst = `DSRF_RST_DIR;
    endcase
  endfunction

  function automatic logic [7:0] doc_msk(input logic [1:0] i);
    case (i)
      2'h0: doc_msk = `DSRF_MSK_FBOPT;
      2'h1: doc_msk = `DSRF_MSK_BASIC;
      2'h2: doc_msk = `DSRF_MSK_RETAIN;
      default: doc_msk = `DSRF_MSK_DIR;
    endcase
  endfunction

  dsrf_pkg::dsrf_state_t state_q, state_d;
  logic [7:0] cv_q [4];
  logic [3:0] cv_hit;
  logic [1:0] hit_idx;
  logic [7:0] wr_merged;
  logic [1:0] init_cnt_q;
  logic [5:0] reg_idx_q, rd_idx_q;
  logic rd_pend_q, rd_cv_q;
  logic pend_addr_q, pend_cv_q, pend_stat_q, pend_reg_q;
  logic [7:0] cv_num_q;
  logic [1:0] stat_sel_q;
  logic [7:0] speed_q;
  logic [28:0] func_q;
  logic power_q, hold_q, dir_q;
  logic fb_valid_q;
  logic [1:0] fb_kind_q;
  logic [15:0] fb_data_q;

  // configuration bits that steer the block
  wire fb_en = cv_q[1][`DSRF_BIT_FB_EN];
  wire autoreg_en = cv_q[0][`DSRF_BIT_AUTOREG];
  wire save_func = cv_q[2][`DSRF_BIT_SAVE_FUNC];
  wire save_spd = cv_q[2][`DSRF_BIT_SAVE_SPD];
  wire dirbit_en = cv_q[3][`DSRF_BIT_DIRBIT];

  // write merge keeps undocumented bits from the shadow copy
  // masked merge
  assign hit_idx = cv_hit[0] ? 2'h0 : cv_hit[1] ? 2'h1 :
    cv_hit[2] ? 2'h2 : 2'h3;
  assign wr_merged = (|cv_hit) ?
    ((reg_wdata & doc_msk(hit_idx)) | (cv_q[hit_idx] & ~doc_msk(hit_idx)))
    : reg_wdata;

  // shadow registers, one per documented variable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cv
      assign cv_hit[gi] = (reg_addr == doc_addr(2'(gi)));
      always_ff @(posedge ref_clk)
      begin
        if (srst)
          cv_q[gi] <= doc_rst(2'(gi));
        else if (reg_wr && cv_hit[gi])
          cv_q[gi] <= wr_merged;
      end
    end
  endgenerate

  // memory port: factory init, then bus, then feedback engine
  wire in_init = (state_q == dsrf_pkg::DSRF_ST_INIT);
  wire bus_busy = reg_wr | reg_rd | in_init;
  wire eng_rd = !bus_busy && (state_q == dsrf_pkg::DSRF_ST_CV ||
    state_q == dsrf_pkg::DSRF_ST_REG);
  wire [7:0] reg_rd_addr = `DSRF_REG_BASE + {2'h0, reg_idx_q};
  assign mif.we = in_init | reg_wr;
  assign mif.re = reg_rd | eng_rd;
  assign mif.wdata = in_init ? doc_rst(init_cnt_q) : wr_merged;
  assign mif.addr = in_init ? doc_addr(init_cnt_q) : bus_busy ? reg_addr :
    (state_q == dsrf_pkg::DSRF_ST_CV) ? cv_num_q : reg_rd_addr;
  assign reg_rdata = mif.rdata;

  // engine decisions in idle; a returning read takes the channel first
  wire idle_free = (state_q == dsrf_pkg::DSRF_ST_IDLE) && !rd_pend_q;
  wire take_addr = idle_free && pend_addr_q;
  wire take_cv = idle_free && !pend_addr_q && pend_cv_q;
  wire take_stat = idle_free && !pend_addr_q && !pend_cv_q && pend_stat_q;
  wire take_reg = idle_free && !pend_addr_q && !pend_cv_q &&
    !pend_stat_q && pend_reg_q && autoreg_en;
  wire reg_done = eng_rd && (state_q == dsrf_pkg::DSRF_ST_REG) &&
    (reg_idx_q == `DSRF_REG_LAST);

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dsrf_pkg::DSRF_ST_INIT:
        if (init_cnt_q == `DSRF_INIT_LAST)
          state_d = dsrf_pkg::DSRF_ST_IDLE;
      dsrf_pkg::DSRF_ST_IDLE:
        if (take_cv)
          state_d = dsrf_pkg::DSRF_ST_CV;
        else if (take_reg)
          state_d = dsrf_pkg::DSRF_ST_REG;
      dsrf_pkg::DSRF_ST_CV:
        if (eng_rd || !fb_en)
          state_d = dsrf_pkg::DSRF_ST_IDLE;
      dsrf_pkg::DSRF_ST_REG:
        if (reg_done || !fb_en || !autoreg_en)
          state_d = dsrf_pkg::DSRF_ST_IDLE;
      default:
        state_d = dsrf_pkg::DSRF_ST_INIT;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_q <= dsrf_pkg::DSRF_ST_INIT;
    else
      state_q <= state_d;
  end

  // init counter and registration walk
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      init_cnt_q <= 2'h0;
      reg_idx_q <= 6'h0;
    end
    else
    begin
      if (in_init)
        init_cnt_q <= init_cnt_q + 2'h1;
      if (take_reg)
        reg_idx_q <= 6'h0;
      else if (eng_rd && state_q == dsrf_pkg::DSRF_ST_REG)
        reg_idx_q <= reg_idx_q + 6'h1;
    end
  end

  // pending requests; a new request wins over its own clear
  // gated by enable
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pend_addr_q <= 1'b0;
      pend_cv_q <= 1'b0;
      pend_stat_q <= 1'b0;
      pend_reg_q <= 1'b0;
    end
    else
    begin
      pend_addr_q <= fb_en && (trk_addr_bcast || (pend_addr_q && !take_addr));
      pend_cv_q <= fb_en && (trk_cv_query || (pend_cv_q && !take_cv));
      pend_stat_q <= fb_en && (trk_stat_query || (pend_stat_q && !take_stat));
      pend_reg_q <= fb_en && autoreg_en &&
        (trk_reg_start || (pend_reg_q && !take_reg));
    end
  end

  // request arguments, latest one stands
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cv_num_q <= 8'h00;
      stat_sel_q <= 2'h0;
    end
    else
    begin
      if (trk_cv_query)
        cv_num_q <= trk_cv_num;
      if (trk_stat_query)
        stat_sel_q <= trk_stat_sel;
    end
  end

  // reads in flight return one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rd_pend_q <= 1'b0;
      rd_cv_q <= 1'b0;
      rd_idx_q <= 6'h0;
    end
    else
    begin
      rd_pend_q <= eng_rd;
      rd_cv_q <= (state_q == dsrf_pkg::DSRF_ST_CV);
      rd_idx_q <= reg_idx_q;
    end
  end

  // status value picked by selector
  wire [7:0] stat_val = (stat_sel_q == 2'h0) ? motor_load :
    (stat_sel_q == 2'h1) ? motor_current : motor_temp;

  // feedback word; address, status and memory returns share it
  // address, variable, status, record
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fb_valid_q <= 1'b0;
      fb_kind_q <= dsrf_pkg::DSRF_FB_ADDR;
      fb_data_q <= 16'h0000;
    end
    else
    begin
      fb_valid_q <= fb_en && (rd_pend_q || take_addr || take_stat);
      if (rd_pend_q)
      begin
        fb_kind_q <= rd_cv_q ? dsrf_pkg::DSRF_FB_CV : dsrf_pkg::DSRF_FB_REG;
        fb_data_q <= rd_cv_q ? {cv_num_q, mif.rdata} :
          {2'h0, rd_idx_q, mif.rdata};
      end
      else if (take_addr)
      begin
        fb_kind_q <= dsrf_pkg::DSRF_FB_ADDR;
        fb_data_q <= {2'h0, loco_addr};
      end
      else if (take_stat)
      begin
        fb_kind_q <= dsrf_pkg::DSRF_FB_STAT;
        fb_data_q <= {6'h00, stat_sel_q, stat_val};
      end
    end
  end

  wire power_lost = power_q && !trk_power_ok;
  wire power_back = !power_q && trk_power_ok;

  // stored speed and functions; survive a power gap only if enabled
  // function store, speed store and hold
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      power_q <= 1'b0;
      speed_q <= `DSRF_SPEED_STOP;
      func_q <= 29'h0;
      hold_q <= 1'b0;
    end
    else
    begin
      power_q <= trk_power_ok;
      if (power_lost && !save_func)
        func_q <= 29'h0;
      else if (trk_func_stb && trk_power_ok)
        func_q <= trk_func;
      if (power_lost)
      begin
        hold_q <= save_spd;
        if (!save_spd)
          speed_q <= `DSRF_SPEED_STOP;
      end
      else if (trk_speed_stb && trk_power_ok)
      begin
        // the hold ends when the station commands a stop
        if (trk_speed == `DSRF_SPEED_STOP)
          hold_q <= 1'b0;
        if (!hold_q || trk_speed == `DSRF_SPEED_STOP)
          speed_q <= trk_speed;
      end
    end
  end

  // direction on entry from an analogue sector
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      dir_q <= 1'b0;
    else if (trk_a2d_entry)
      dir_q <= dirbit_en ? trk_analog_dir : trk_dir;
    else if (trk_speed_stb && trk_power_ok && !hold_q)
      dir_q <= trk_dir;
  end

  // speed and function outputs, drive zero while track power is absent
  logic [7:0] drv_speed_q;
  logic [28:0] drv_func_q;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      drv_speed_q <= `DSRF_SPEED_STOP;
      drv_func_q <= 29'h0;
    end
    else
    begin
      drv_speed_q <= trk_power_ok ? speed_q : `DSRF_SPEED_STOP;
      drv_func_q <= trk_power_ok ? func_q : 29'h0;
    end
  end

  assign drv_speed = drv_speed_q;
  assign drv_func = drv_func_q;
  assign drv_dir = dir_q;
  assign resume_hold = hold_q;
  assign fb_valid = fb_valid_q;
  assign fb_kind = fb_kind_q;
  assign fb_data = fb_data_q;

  // checks
  property p_dirbit;
    @(posedge ref_clk) disable iff (srst)
    trk_a2d_entry && dirbit_en |=> drv_dir == $past(trk_analog_dir);
  endproperty
  a_dirbit: assert property (p_dirbit) else $error("dir bit");

  // stored functions must not move while the track is dead
  property p_func_restore;
    @(posedge ref_clk) disable iff (srst)
    !trk_power_ok && save_func |=> func_q == $past(func_q);
  endproperty
  a_func_restore: assert property (p_func_restore)
    else $error("functions not restored");

  property p_speed_hold;
    @(posedge ref_clk) disable iff (srst)
    hold_q && trk_speed_stb && trk_speed != `DSRF_SPEED_STOP
    |=> speed_q == $past(speed_q);
  endproperty
  a_speed_hold: assert property (p_speed_hold)
    else $error("held speed changed");

  property p_addr_fb;
    @(posedge ref_clk) disable iff (srst)
    take_addr && fb_en |=> fb_valid &&
    fb_kind == dsrf_pkg::DSRF_FB_ADDR && fb_data[13:0] == $past(loco_addr);
  endproperty
  a_addr_fb: assert property (p_addr_fb) else $error("address");

  property p_cv_fb;
    @(posedge ref_clk) disable iff (srst)
    rd_pend_q && rd_cv_q && fb_en |=> fb_valid &&
    fb_kind == dsrf_pkg::DSRF_FB_CV && fb_data[7:0] == $past(reg_rdata);
  endproperty
  a_cv_fb: assert property (p_cv_fb) else $error("cv report");

  property p_stat_fb;
    @(posedge ref_clk) disable iff (srst)
    take_stat && fb_en |=> fb_kind == dsrf_pkg::DSRF_FB_STAT &&
    fb_data[7:0] == $past(stat_val);
  endproperty
  a_stat_fb: assert property (p_stat_fb) else $error("status");

  property p_fb_gate;
    @(posedge ref_clk) disable iff (srst)
    fb_valid |-> $past(fb_en);
  endproperty
  a_fb_gate: assert property (p_fb_gate) else $error("fb off");

  property p_reg_off;
    @(posedge ref_clk) disable iff (srst)
    !autoreg_en |=> state_q != dsrf_pkg::DSRF_ST_REG;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("reg off");

  property p_reg_end;
    @(posedge ref_clk) disable iff (srst)
    reg_done |=> state_q == dsrf_pkg::DSRF_ST_IDLE ##1
    fb_valid && fb_data[13:8] == `DSRF_REG_LAST;
  endproperty
  a_reg_end: assert property (p_reg_end) else $error("reg end");

  property p_keep_bits;
    @(posedge ref_clk) disable iff (srst)
    reg_wr && cv_hit[2] |=> cv_q[2][7:2] == $past(cv_q[2][7:2]);
  endproperty
  a_keep_bits: assert property (p_keep_bits)
    else $error("reserved bits changed");

  c_reg_walk: cover property (@(posedge ref_clk) disable iff (srst)
    reg_done);
  c_resume: cover property (@(posedge ref_clk) disable iff (srst)
    power_back && hold_q);
  c_cv_report: cover property (@(posedge ref_clk) disable iff (srst)
    fb_valid && fb_kind == dsrf_pkg::DSRF_FB_CV);
endmodule
`default_nettype wire

// file: verif/dsrf_station_model.sv
`default_nettype none
// command station side: track power and one-cycle request strobes
module dsrf_station_model (
  input wire logic ref_clk,
  output var logic trk_power_ok,
  output logic trk_speed_stb,
  output logic [7:0] trk_speed,
  output logic trk_dir,
  output logic trk_func_stb,
  output logic [28:0] trk_func,
  output logic trk_a2d_entry,
  output logic trk_analog_dir,
  output logic trk_addr_bcast,
  output logic trk_cv_query,
  output logic [7:0] trk_cv_num,
  output logic trk_stat_query,
  output logic [1:0] trk_stat_sel,
  output logic trk_reg_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] stb_q = 7'h00;
  logic [28:0] arg_q = 29'h0;
  initial trk_power_ok = 1'b1;
  // arguments stay as levels after the strobe, like a real packet decode
  assign trk_speed_stb = stb_q[0];
  assign trk_func_stb = stb_q[1];
  assign trk_a2d_entry = stb_q[2];
  assign trk_addr_bcast = stb_q[3];
  assign trk_cv_query = stb_q[4];
  assign trk_stat_query = stb_q[5];
  assign trk_reg_start = stb_q[6];
  assign trk_speed = arg_q[7:0];
  assign trk_dir = arg_q[8];
  assign trk_analog_dir = arg_q[9];
  assign trk_func = arg_q;
  assign trk_cv_num = arg_q[7:0];
  assign trk_stat_sel = arg_q[1:0];
  // one request: k selects the strobe, held for exactly one cycle
  task automatic cmd(input int k, input logic [28:0] arg);
    @(posedge ref_clk);
    arg_q <= arg;
    stb_q <= 7'h01 << k;
    @(posedge ref_clk);
    stb_q <= 7'h00;
  endtask
  // track power switching
  task automatic power(input logic on);
    @(posedge ref_clk);
    trk_power_ok <= on;
  endtask
endmodule
`default_nettype wire

// file: verif/test_decoder_state_retention_feedback.sv
`include "dsrf_params.svh"
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  err_total++; end end
module test_decoder_state_retention_feedback;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [13:0] loco_addr = 14'h2A5C;
  logic [7:0] mval [4] = '{8'h11, 8'h22, 8'h33, 8'h33};
  wire logic [7:0] reg_rdata, trk_speed, trk_cv_num, drv_speed;
  wire logic [28:0] trk_func, drv_func;
  wire logic [1:0] trk_stat_sel, fb_kind;
  wire logic [15:0] fb_data;
  wire logic pwr, sp_stb, dir, fn_stb, a2d, adir, bc, cvq, stq, rgs;
  wire logic drv_dir, resume_hold, fb_valid;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [15:0] w5;
  bit got;
  int cnt;
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  dsrf_station_model st (.ref_clk(ref_clk), .trk_power_ok(pwr),
    .trk_speed_stb(sp_stb), .trk_speed(trk_speed), .trk_dir(dir),
    .trk_func_stb(fn_stb), .trk_func(trk_func), .trk_a2d_entry(a2d),
    .trk_analog_dir(adir), .trk_addr_bcast(bc), .trk_cv_query(cvq),
    .trk_cv_num(trk_cv_num), .trk_stat_query(stq),
    .trk_stat_sel(trk_stat_sel), .trk_reg_start(rgs));
  dsrf_top dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trk_power_ok(pwr), .trk_speed_stb(sp_stb),
    .trk_speed(trk_speed), .trk_dir(dir), .trk_func_stb(fn_stb),
    .trk_func(trk_func), .trk_a2d_entry(a2d), .trk_analog_dir(adir),
    .trk_addr_bcast(bc), .trk_cv_query(cvq), .trk_cv_num(trk_cv_num),
    .trk_stat_query(stq), .trk_stat_sel(trk_stat_sel),
    .trk_reg_start(rgs), .loco_addr(loco_addr), .motor_load(mval[0]),
    .motor_current(mval[1]), .motor_temp(mval[2]),
    .drv_speed(drv_speed), .drv_dir(drv_dir), .drv_func(drv_func),
    .resume_hold(resume_hold), .fb_valid(fb_valid), .fb_kind(fb_kind),
    .fb_data(fb_data));
  // verdict and end of run
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bus write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // bus read: data only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // bounded wait for a feedback word
  task automatic wait_fb(input int n);
    got = 1'b0;
    cnt = 0;
    while (!got && cnt < n)
    begin
      @(posedge ref_clk);
      #1;
      got = (fb_valid === 1'b1);
      cnt++;
    end
  endtask
  // expected feedback word; a missing one ends the run
  task automatic fb_chk(input logic [1:0] k, input logic [15:0] e);
    wait_fb(12);
    if (!got)
    begin
      err_total++;
      print_verdict();
    end
    else
    begin
      `CHK(fb_kind, k)
      `CHK(fb_data, e)
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rchk(`DSRF_CV_FBOPT, `DSRF_RST_FBOPT);
    rchk(`DSRF_CV_BASIC, `DSRF_RST_BASIC);
    rchk(`DSRF_CV_RETAIN, `DSRF_RST_RETAIN);
    rchk(`DSRF_CV_DIR, `DSRF_RST_DIR);
    // undocumented bits keep their value
    wr(`DSRF_CV_BASIC, 8'hFF);
    wr(`DSRF_CV_RETAIN, 8'hFC);
    wr(`DSRF_CV_DIR, 8'hFE);
    wr(8'h40, 8'hA5);
    rchk(`DSRF_CV_BASIC, 8'h08);
    rchk(`DSRF_CV_RETAIN, 8'h00);
    rchk(`DSRF_CV_DIR, 8'h00);
    rchk(8'h40, 8'hA5);
    st.cmd(3, 29'h0);
    fb_chk(2'h0, {2'b00, loco_addr});
    st.cmd(4, 29'h40);
    fb_chk(2'h1, 16'h40A5);
    for (int i = 0; i < 4; i++)
    begin
      st.cmd(5, 29'(i));
      fb_chk(2'h2, {6'h00, 2'(i), mval[i]});
    end
    // bus writes an edited record byte, then the station starts registration
    wr(8'hC5, 8'h3C);
    st.cmd(6, 29'h0);
    cnt = 0;
    w5 = 16'h0;
    repeat (150)
    begin
      @(posedge ref_clk);
      #1;
      if (fb_valid === 1'b1 && fb_kind === 2'h3)
        cnt++;
      if (fb_valid === 1'b1 && fb_data[13:8] === 6'h05)
        w5 = fb_data;
    end
    `CHK(cnt, 64)
    `CHK(w5, 16'h053C)
    wr(`DSRF_CV_FBOPT, 8'h00);
    st.cmd(6, 29'h0);
    wait_fb(80);
    `CHK(got, 1'b0)
    wr(`DSRF_CV_BASIC, 8'h00);
    st.cmd(3, 29'h0);
    wait_fb(12);
    `CHK(got, 1'b0)
    // save both, then a power interruption
    wr(`DSRF_CV_RETAIN, 8'h03);
    st.cmd(0, 29'h155);
    st.cmd(1, 29'h1234567);
    settle();
    `CHK(drv_speed, 8'h55)
    st.power(1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(drv_speed, 8'h00)
    `CHK(drv_func, 29'h0)
    // hold is already up from the loss; let the outputs come back
    st.power(1'b1);
    settle();
    `CHK(resume_hold, 1'b1)
    `CHK(drv_speed, 8'h55)
    `CHK(drv_func, 29'h1234567)
    st.cmd(0, 29'h120);
    settle();
    `CHK(drv_speed, 8'h55)
    st.cmd(0, 29'h0);
    settle();
    `CHK(resume_hold, 1'b0)
    // saving off: nothing comes back
    wr(`DSRF_CV_RETAIN, 8'h00);
    st.power(1'b0);
    st.power(1'b1);
    settle();
    `CHK(drv_func, 29'h0)
    `CHK(resume_hold, 1'b0)
    // analogue entry: direction flips 1 to 0 to 1, so both paths show
    wr(`DSRF_CV_DIR, 8'h00);
    st.cmd(2, 29'h200);
    settle();
    `CHK(drv_dir, 1'b0)
    wr(`DSRF_CV_DIR, 8'h01);
    st.cmd(2, 29'h200);
    settle();
    `CHK(drv_dir, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
